// *** common/sdc_pkg.sv ***
// shared constants and types for the sdram command core
package sdc_pkg;
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int COL_W = 9;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int BYTES = 2;
  localparam int SYNC_STAGES = 3;
  localparam int SCOPE_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_THREE = 3'h3;
  localparam logic [11:0] MODE_RESET = 12'h030;
  // strobe codes {row, column, write}, all active low
  localparam logic [2:0] STB_NOP = 3'h7;
  localparam logic [2:0] STB_STOP = 3'h6;
  localparam logic [2:0] STB_READ = 3'h5;
  localparam logic [2:0] STB_WRITE = 3'h4;
  localparam logic [2:0] STB_ACT = 3'h3;
  localparam logic [2:0] STB_PRE = 3'h2;
  localparam logic [2:0] STB_REFRESH = 3'h1;
  localparam logic [2:0] STB_MODE = 3'h0;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_STOP, CMD_READ, CMD_WRITE,
    CMD_ACT, CMD_PRE, CMD_REFRESH, CMD_MODE_LOAD
  } sdc_cmd_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b11
  } sdc_burst_t;
endpackage

// *** common/sdc_rd_if.sv ***
// read data path between the core and its output pipe
`timescale 1ns/10ps
interface sdc_rd_if;
  import sdc_pkg::*;
  logic [DATA_W-1:0] word;
  logic valid;
  logic [BYTES-1:0] mask;
  logic casThree;
  logic [DATA_W-1:0] dqOut;
  logic [BYTES-1:0] dqOe;
  modport core (
    output word,
    output valid,
    output mask,
    output casThree,
    input dqOut,
    input dqOe
  );
  modport pipe (
    input word,
    input valid,
    input mask,
    input casThree,
    output dqOut,
    output dqOe
  );
endinterface

// *** design/sdc_command_core.sv ***
// command decode, bank state, burst engine and array of the sdram core
`timescale 1ns/10ps
module sdc_command_core import sdc_pkg::*; #(
  parameter int BANK_BITS = BANK_W,
  parameter int ROW_BITS = ROW_W,
  parameter int COL_BITS = COL_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clockGate,
  input wire logic chipSelN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeStrobeN,
  input wire logic [BANK_BITS-1:0] bankSelectBits,
  input wire logic [ROW_BITS-1:0] rowOrOpcodeBits,
  input wire logic lowByteMask,
  input wire logic highByteMask,
  input wire logic [DATA_W-1:0] dqIn,
  output logic [DATA_W-1:0] dqOut,
  output logic [BYTES-1:0] dqOe,
  output logic [(1<<BANK_BITS)-1:0] bankOpen,
  output logic burstBusy,
  output logic [ROW_BITS-1:0] modeReg,
  output logic refreshPulse,
  output logic [BANK_BITS-1:0] refreshBank,
  output logic [ROW_BITS-1:0] refreshRow
);
  localparam int BANKS = 1 << BANK_BITS;
  localparam int ADDR_W = BANK_BITS + ROW_BITS + COL_BITS;
  localparam int REF_W = BANK_BITS + ROW_BITS;

  function automatic sdc_cmd_t cmdDecode(
    input logic selN,
    input logic [2:0] strobes
  );
    sdc_cmd_t c;
    c = CMD_NOP;
    if (!selN) begin
      case (strobes)
        STB_NOP: c = CMD_NOP;
        STB_STOP: c = CMD_STOP;
        STB_READ: c = CMD_READ;
        STB_WRITE: c = CMD_WRITE;
        STB_ACT: c = CMD_ACT;
        STB_PRE: c = CMD_PRE;
        STB_REFRESH: c = CMD_REFRESH;
        STB_MODE: c = CMD_MODE_LOAD;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // burst length less one, as a wrap mask on the column
  function automatic logic [COL_BITS-1:0] lenMask(
    input logic [2:0] code
  );
    logic [COL_BITS-1:0] m;
    m = '0;
    case (code)
      BL_1: m = '0;
      BL_2: m = COL_BITS'(1);
      BL_4: m = COL_BITS'(3);
      BL_8: m = COL_BITS'(7);
      BL_PAGE: m = '1;
      default: m = '0;
    endcase
    return m;
  endfunction

  function automatic logic [COL_BITS-1:0] colOf(
    input logic [COL_BITS-1:0] start,
    input logic [COL_BITS-1:0] idx,
    input logic [COL_BITS-1:0] m,
    input logic interleave
  );
    logic [COL_BITS-1:0] low;
    low = interleave ? (start ^ idx) : COL_BITS'(start + idx);
    return (start & ~m) | (low & m);
  endfunction

  // clock gate arrives asynchronously; three stages, last two agree
  logic [SYNC_STAGES-1:0] gateSync_reg;
  logic gateOn_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      gateSync_reg <= '0;
    end else begin
      gateSync_reg <= {gateSync_reg[SYNC_STAGES-2:0], clockGate};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gateOn_reg <= 1'b0;
    end else if (gateSync_reg[SYNC_STAGES-1] ==
                 gateSync_reg[SYNC_STAGES-2]) begin
      gateOn_reg <= gateSync_reg[SYNC_STAGES-1];
    end
  end

  // command formation; all pins taken at this rising edge
  sdc_cmd_t cmd;
  logic [BANK_BITS-1:0] cmdBank;
  logic [COL_BITS-1:0] cmdCol;
  logic scopeHigh;
  logic [BYTES-1:0] byteMask;

  always_comb begin
    cmd = CMD_NOP;
    if (gateOn_reg) begin
      cmd = cmdDecode(chipSelN,
        {rowStrobeN, colStrobeN, writeStrobeN});
    end
  end

  assign cmdBank = bankSelectBits;
  assign cmdCol = rowOrOpcodeBits[COL_BITS-1:0];
  assign scopeHigh = rowOrOpcodeBits[SCOPE_BIT];
  assign byteMask = {highByteMask, lowByteMask};

  // bank and mode state
  logic [BANKS-1:0] bankOpen_reg;
  logic [ROW_BITS-1:0] bankRow_reg [BANKS];
  logic [ROW_BITS-1:0] modeReg_reg;
  logic [COL_BITS-1:0] wrap;
  logic interleave;
  logic pageMode;

  assign wrap = lenMask(modeReg_reg[MR_BL_LSB +: 3]);
  assign interleave = modeReg_reg[MR_BT_BIT];
  assign pageMode = (modeReg_reg[MR_BL_LSB +: 3] == BL_PAGE);

  // burst engine
  sdc_burst_t state_reg;
  sdc_burst_t state_next;
  logic [BANK_BITS-1:0] bank_reg;
  logic [BANK_BITS-1:0] bank_next;
  logic [COL_BITS-1:0] start_reg;
  logic [COL_BITS-1:0] start_next;
  logic [COL_BITS-1:0] idx_reg;
  logic [COL_BITS-1:0] idx_next;
  logic auto_reg;
  logic auto_next;

  logic startBurst;
  logic cutByPre;
  logic beatValid;
  logic beatWrite;
  logic [BANK_BITS-1:0] beatBank;
  logic [COL_BITS-1:0] beatCol;
  logic closeOld;
  logic closeNew;

  // accesses to an idle bank are not legal and are dropped
  assign startBurst = (cmd == CMD_READ || cmd == CMD_WRITE) &&
                      bankOpen_reg[cmdBank];
  assign cutByPre = (cmd == CMD_PRE) &&
                    (scopeHigh || cmdBank == bank_reg);

  always_comb begin
    state_next = state_reg;
    bank_next = bank_reg;
    start_next = start_reg;
    idx_next = idx_reg;
    auto_next = auto_reg;
    beatValid = 1'b0;
    beatWrite = (state_reg == ST_WRITE);
    beatBank = bank_reg;
    beatCol = colOf(start_reg, idx_reg, wrap, interleave);
    closeOld = 1'b0;
    closeNew = 1'b0;
    if (startBurst) begin
      // a new access cuts any running burst
      state_next = (cmd == CMD_WRITE) ? ST_WRITE : ST_READ;
      bank_next = cmdBank;
      start_next = cmdCol;
      auto_next = scopeHigh;
      beatValid = 1'b1;
      beatWrite = (cmd == CMD_WRITE);
      beatBank = cmdBank;
      beatCol = cmdCol;
      idx_next = COL_BITS'(1);
      if (state_reg != ST_IDLE && auto_reg && bank_reg != cmdBank) begin
        closeOld = 1'b1;
      end
      if (wrap == '0 && !pageMode) begin
        state_next = ST_IDLE;
        closeNew = scopeHigh;
      end
    end else if (state_reg != ST_IDLE) begin
      if (cmd == CMD_STOP || cutByPre) begin
        // row stays open after a stop; no auto precharge then
        state_next = ST_IDLE;
      end else if (gateOn_reg) begin
        beatValid = 1'b1;
        if (idx_reg == wrap && !pageMode) begin
          state_next = ST_IDLE;
          closeOld = auto_reg;
        end else begin
          idx_next = COL_BITS'(idx_reg + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      bank_reg <= '0;
      start_reg <= '0;
      idx_reg <= '0;
      auto_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bank_reg <= bank_next;
      start_reg <= start_next;
      idx_reg <= idx_next;
      auto_reg <= auto_next;
    end
  end

  // per-bank open flags and rows
  always_ff @(posedge clk) begin
    if (rst) begin
      bankOpen_reg <= '0;
      for (int b = 0; b < BANKS; b++) begin
        bankRow_reg[b] <= '0;
      end
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        if (cmd == CMD_ACT && cmdBank == BANK_BITS'(b) &&
            !bankOpen_reg[b]) begin
          bankOpen_reg[b] <= 1'b1;
          bankRow_reg[b] <= rowOrOpcodeBits;
        end else if (cmd == CMD_PRE &&
                     (scopeHigh || cmdBank == BANK_BITS'(b))) begin
          bankOpen_reg[b] <= 1'b0;
        end else if ((closeOld && bank_reg == BANK_BITS'(b)) ||
                     (closeNew && cmdBank == BANK_BITS'(b))) begin
          bankOpen_reg[b] <= 1'b0;
        end
      end
    end
  end

  // mode load only takes effect with every bank idle
  always_ff @(posedge clk) begin
    if (rst) begin
      modeReg_reg <= MODE_RESET;
    end else if (cmd == CMD_MODE_LOAD && bankOpen_reg == '0 &&
                 state_reg == ST_IDLE) begin
      modeReg_reg <= rowOrOpcodeBits;
    end
  end

  // refresh walks banks fastest, then rows; pins are ignored
  logic [REF_W-1:0] refCount_reg;
  logic refreshPulse_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      refCount_reg <= '0;
      refreshPulse_reg <= 1'b0;
    end else begin
      refreshPulse_reg <= 1'b0;
      if (cmd == CMD_REFRESH && bankOpen_reg == '0) begin
        refreshPulse_reg <= 1'b1;
        refCount_reg <= REF_W'(refCount_reg + 1'b1);
      end
    end
  end

  // storage array; simulators size it from the parameters
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] beatAddr;
  logic [BYTES-1:0] wrByte;
  logic [DATA_W-1:0] rdWord_reg;
  logic rdValid_reg;

  assign beatAddr = {beatBank, bankRow_reg[beatBank], beatCol};

  generate
    for (genvar g = 0; g < BYTES; g++) begin : gByte
      // data and mask arrive together, no mask delay on writes
      assign wrByte[g] = beatValid && beatWrite && !byteMask[g];
    end
  endgenerate

  always_ff @(posedge clk) begin
    for (int b = 0; b < BYTES; b++) begin
      if (wrByte[b]) begin
        mem[beatAddr][b*BYTE_W +: BYTE_W] <=
          dqIn[b*BYTE_W +: BYTE_W];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdWord_reg <= '0;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= beatValid && !beatWrite;
      if (beatValid && !beatWrite) begin
        rdWord_reg <= mem[beatAddr];
      end
    end
  end

  sdc_rd_if rdLink ();

  assign rdLink.word = rdWord_reg;
  assign rdLink.valid = rdValid_reg;
  assign rdLink.mask = byteMask;
  assign rdLink.casThree =
    (modeReg_reg[MR_CL_LSB +: 3] == CL_THREE);

  sdc_read_pipe uPipe (
    .clk(clk),
    .rst(rst),
    .rd(rdLink.pipe)
  );

  assign dqOut = rdLink.dqOut;
  assign dqOe = rdLink.dqOe;
  assign bankOpen = bankOpen_reg;
  assign burstBusy = (state_reg != ST_IDLE);
  assign modeReg = modeReg_reg;
  assign refreshPulse = refreshPulse_reg;
  assign refreshBank = refCount_reg[BANK_BITS-1:0];
  assign refreshRow = refCount_reg[REF_W-1:BANK_BITS];
endmodule

// *** design/sdc_read_pipe.sv ***
// read latency and byte mask delay pipe
`timescale 1ns/10ps
module sdc_read_pipe import sdc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  sdc_rd_if.pipe rd
);
  logic [DATA_W-1:0] stage1_reg;
  logic [DATA_W-1:0] stage2_reg;
  logic [1:0] valid_reg;
  logic [BYTES-1:0] maskA_reg;
  logic [BYTES-1:0] maskB_reg;
  logic pickValid;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      valid_reg <= '0;
    end else begin
      stage1_reg <= rd.word;
      stage2_reg <= stage1_reg;
      valid_reg <= {valid_reg[0], rd.valid};
    end
  end

  // mask seen at edge m governs data sampled at edge m+2
  always_ff @(posedge clk) begin
    if (rst) begin
      maskA_reg <= '1;
      maskB_reg <= '1;
    end else begin
      maskA_reg <= rd.mask;
      maskB_reg <= maskA_reg;
    end
  end

  assign pickValid = rd.casThree ? valid_reg[1] : valid_reg[0];
  assign rd.dqOut = rd.casThree ? stage2_reg : stage1_reg;
  // masked byte releases its lanes
  assign rd.dqOe = {BYTES{pickValid}} & ~maskB_reg;
endmodule

// *** verification/sdc_command_core_assertions.sv ***
// concurrent checks on the ports of the sdram command core
`timescale 1ns/10ps
module sdc_command_core_assertions import sdc_pkg::*; #(
  parameter int BANK_BITS = BANK_W,
  parameter int ROW_BITS = ROW_W,
  parameter int COL_BITS = COL_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clockGate,
  input wire logic chipSelN,
  input wire logic rowStrobeN,
  input wire logic colStrobeN,
  input wire logic writeStrobeN,
  input wire logic [BANK_BITS-1:0] bankSelectBits,
  input wire logic [ROW_BITS-1:0] rowOrOpcodeBits,
  input wire logic lowByteMask,
  input wire logic highByteMask,
  input wire logic [DATA_W-1:0] dqIn,
  input wire logic [DATA_W-1:0] dqOut,
  input wire logic [BYTES-1:0] dqOe,
  input wire logic [(1<<BANK_BITS)-1:0] bankOpen,
  input wire logic burstBusy,
  input wire logic [ROW_BITS-1:0] modeReg,
  input wire logic refreshPulse,
  input wire logic [BANK_BITS-1:0] refreshBank,
  input wire logic [ROW_BITS-1:0] refreshRow
);
  logic [2:0] okCnt;
  logic [2:0] stb;
  logic taken;
  logic [ROW_BITS+BANK_BITS-1:0] rfCnt;
  assign stb = {rowStrobeN, colStrobeN, writeStrobeN};
  assign taken = (okCnt == 3'h7) && !chipSelN;
  assign rfCnt = {refreshRow, refreshBank};
  // waits well past the gate synchroniser, so some commands go unchecked
  always_ff @(posedge clk) begin
    if (rst || !clockGate) begin
      okCnt <= 3'h0;
    end else if (okCnt != 3'h7) begin
      okCnt <= okCnt + 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence pre_all_s;
    taken && stb == STB_PRE && rowOrOpcodeBits[SCOPE_BIT];
  endsequence
  sequence pre_one_s;
    taken && stb == STB_PRE && !rowOrOpcodeBits[SCOPE_BIT];
  endsequence
  desel_hold_a: assert property (
    chipSelN && !burstBusy |=> $stable(bankOpen))
    else $error("bank state moved while deselected");
  mode_load_a: assert property (
    $changed(modeReg) && !$past(rst) |->
    $past(!chipSelN && stb == STB_MODE && bankOpen == '0)
    && modeReg == $past(rowOrOpcodeBits))
    else $error("mode register changed without a legal load");
  refresh_cmd_a: assert property (
    $rose(refreshPulse) |->
    $past(!chipSelN && stb == STB_REFRESH && bankOpen == '0))
    else $error("refresh pulse without a refresh command");
  refresh_step_a: assert property (
    $changed(rfCnt) && !$past(rst) |-> rfCnt == $past(rfCnt) + 1'b1)
    else $error("refresh counter did not step by one");
  act_open_a: assert property (
    (bankOpen & ~$past(bankOpen)) != '0 |->
    $past(!chipSelN && stb == STB_ACT)
    && bankOpen == ($past(bankOpen) | (1 << $past(bankSelectBits))))
    else $error("bank opened without matching activate");
  pre_all_a: assert property (pre_all_s |=> bankOpen == '0)
    else $error("precharge all left a bank open");
  pre_one_a: assert property (
    pre_one_s |=> !bankOpen[$past(bankSelectBits)])
    else $error("precharged bank still open");
  stop_idle_a: assert property (
    taken && stb == STB_STOP |=> !burstBusy)
    else $error("burst survived a terminate");
  rd_refused_a: assert property (
    taken && stb == STB_READ && !burstBusy && !bankOpen[bankSelectBits]
    |=> !burstBusy)
    else $error("read to idle bank started a burst");
  mask_hi_a: assert property ($past(highByteMask, 2) |-> !dqOe[1])
    else $error("masked high byte driven");
  mask_lo_a: assert property ($past(lowByteMask, 2) |-> !dqOe[0])
    else $error("masked low byte driven");
endmodule
bind sdc_command_core sdc_command_core_assertions #(
  .BANK_BITS(BANK_BITS), .ROW_BITS(ROW_BITS), .COL_BITS(COL_BITS)
) i_chk (
  .clk(clk), .rst(rst), .clockGate(clockGate), .chipSelN(chipSelN),
  .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
  .writeStrobeN(writeStrobeN), .bankSelectBits(bankSelectBits),
  .rowOrOpcodeBits(rowOrOpcodeBits), .lowByteMask(lowByteMask),
  .highByteMask(highByteMask), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
  .bankOpen(bankOpen), .burstBusy(burstBusy), .modeReg(modeReg),
  .refreshPulse(refreshPulse), .refreshBank(refreshBank),
  .refreshRow(refreshRow)
);

// *** verification/sdc_command_core_tb.sv ***
// testbench for the sdram command core
`timescale 1ns/10ps
module sdc_command_core_tb import sdc_pkg::*; ();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clockGate = 1'b1;
  logic chipSelN;
  logic [2:0] stb;
  logic [1:0] bank, mask, dqOe, refreshBank;
  logic [11:0] addr, modeReg, refreshRow;
  logic [15:0] dqIn, dqOut;
  logic [3:0] bankOpen;
  logic burstBusy, refreshPulse;
  int fails = 0;
  int num_checks = 0;
  always #20 clk = ~clk;
  sdc_ctrl_model i_ctl (.clk(clk), .chipSelN(chipSelN), .stb(stb),
    .bank(bank), .addr(addr), .mask(mask), .data(dqIn));
  sdc_command_core i_dut (.clk(clk), .rst(rst), .clockGate(clockGate),
    .chipSelN(chipSelN), .rowStrobeN(stb[2]), .colStrobeN(stb[1]),
    .writeStrobeN(stb[0]), .bankSelectBits(bank), .rowOrOpcodeBits(addr),
    .lowByteMask(mask[0]), .highByteMask(mask[1]), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .bankOpen(bankOpen),
    .burstBusy(burstBusy), .modeReg(modeReg), .refreshPulse(refreshPulse),
    .refreshBank(refreshBank), .refreshRow(refreshRow));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // read at cas latency two; data compared only on driven bytes
  task automatic rd(input logic [1:0] b, input logic [11:0] a,
      input logic [1:0] m, input logic [15:0] d, input logic [1:0] oe);
    i_ctl.cmd(1'b0, STB_READ, b, a, m);
    i_ctl.idle(2);
    chk(16'(dqOe), 16'(oe));
    chk(dqOut & {{8{oe[1]}}, {8{oe[0]}}}, d);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    test_done();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    i_ctl.idle(6);
    chk(16'(modeReg), 16'h0030);
    chk(16'({bankOpen, dqOe, burstBusy}), 16'h0000);
    $display("test reset done");
    i_ctl.cmd(1'b0, STB_MODE, 2'h0, 12'h020);
    i_ctl.cmd(1'b0, STB_REFRESH, 2'h3, 12'hfff);
    i_ctl.idle(1);
    chk(16'(refreshPulse), 16'h0001);
    i_ctl.idle(3);
    chk(16'(modeReg), 16'h0020);
    chk(16'({refreshRow, refreshBank}), 16'h0001);
    $display("test mode_refresh done");
    i_ctl.cmd(1'b0, STB_ACT, 2'h1, 12'h005);
    i_ctl.cmd(1'b1, STB_ACT, 2'h2, 12'h006);
    i_ctl.cmd(1'b0, STB_MODE, 2'h0, 12'h033);
    i_ctl.idle(2);
    chk(16'(bankOpen), 16'h0002);
    chk(16'(modeReg), 16'h0020);
    i_ctl.cmd(1'b0, STB_WRITE, 2'h1, 12'h003, 2'h0, 16'h1234);
    i_ctl.cmd(1'b0, STB_WRITE, 2'h1, 12'h003, 2'h2, 16'habcd);
    rd(2'h1, 12'h003, 2'h0, 16'h12cd, 2'h3);
    rd(2'h1, 12'h003, 2'h2, 16'h00cd, 2'h1);
    i_ctl.cmd(1'b0, STB_WRITE, 2'h1, 12'h404, 2'h0, 16'h5555);
    i_ctl.idle(2);
    chk(16'(bankOpen), 16'h0000);
    rd(2'h1, 12'h004, 2'h0, 16'h0000, 2'h0);
    $display("test rw done");
    i_ctl.cmd(1'b0, STB_ACT, 2'h0, 12'h001);
    i_ctl.cmd(1'b0, STB_ACT, 2'h3, 12'h002);
    i_ctl.cmd(1'b0, STB_PRE, 2'h3, 12'h000);
    i_ctl.idle(2);
    chk(16'(bankOpen), 16'h0001);
    i_ctl.cmd(1'b0, STB_ACT, 2'h2, 12'h003);
    i_ctl.cmd(1'b0, STB_PRE, 2'h1, 12'h400);
    i_ctl.idle(2);
    chk(16'(bankOpen), 16'h0000);
    $display("test precharge done");
    i_ctl.cmd(1'b0, STB_MODE, 2'h0, 12'h023);
    i_ctl.cmd(1'b0, STB_ACT, 2'h2, 12'h007);
    i_ctl.cmd(1'b0, STB_READ, 2'h2, 12'h000);
    i_ctl.idle(1);
    chk(16'(burstBusy), 16'h0001);
    i_ctl.cmd(1'b0, STB_STOP, 2'h0, 12'h000);
    i_ctl.idle(1);
    chk(16'({bankOpen, burstBusy}), 16'h0008);
    $display("test stop done");
    clockGate = 1'b0;
    i_ctl.idle(5);
    i_ctl.cmd(1'b0, STB_ACT, 2'h0, 12'h008);
    i_ctl.idle(2);
    chk(16'(bankOpen), 16'h0004);
    clockGate = 1'b1;
    i_ctl.idle(6);
    i_ctl.cmd(1'b0, STB_ACT, 2'h0, 12'h008);
    i_ctl.idle(2);
    chk(16'(bankOpen), 16'h0005);
    $display("test gate done");
    // cas latency three: mask at the command edge no longer governs
    i_ctl.cmd(1'b0, STB_PRE, 2'h0, 12'h400);
    i_ctl.cmd(1'b0, STB_MODE, 2'h0, 12'h030);
    i_ctl.cmd(1'b0, STB_ACT, 2'h1, 12'h005);
    i_ctl.cmd(1'b0, STB_READ, 2'h1, 12'h003, 2'h3);
    i_ctl.idle(3);
    chk(16'(dqOe), 16'h0003);
    chk(dqOut, 16'h12cd);
    $display("test latency three done");
    test_done();
  end
endmodule

// *** verification/sdc_ctrl_model.sv ***
// memory controller model driving the command pins of the core
`timescale 1ns/10ps
module sdc_ctrl_model import sdc_pkg::*; (
  input wire logic clk,
  output logic chipSelN,
  output logic [2:0] stb,
  output logic [1:0] bank,
  output logic [11:0] addr,
  output logic [1:0] mask,
  output logic [15:0] data
);
  initial begin
    chipSelN = 1'b1;
    stb = STB_NOP;
    bank = 2'h0;
    addr = 12'h000;
    mask = 2'h0;
    data = 16'h0000;
  end
  // data and masks travel with their command in one cycle
  task automatic cmd(input logic cs, input logic [2:0] s,
      input logic [1:0] b, input logic [11:0] a,
      input logic [1:0] m = 2'h0, input logic [15:0] d = 16'h0000);
    @(negedge clk);
    chipSelN = cs;
    stb = s;
    bank = b;
    addr = a;
    mask = m;
    data = d;
    @(posedge clk);
  endtask
  // released lines toggle so stale values never look valid
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk);
      chipSelN = 1'b0;
      stb = STB_NOP;
      mask = 2'h0;
      addr = ~addr;
      data = ~data;
    end
  endtask
endmodule
